// ===== pkg/sfr_pkg.sv
package sfr_pkg;
	// ==========================================
	// Buffer geometry
	localparam int AW = 9;
	localparam int CW = 10;
	localparam logic [9:0] SETS_3AX = 10'h0aa;
	localparam logic [9:0] SETS_2AX = 10'h100;
	localparam logic [9:0] SETS_1AX = 10'h200;
	localparam logic [9:0] CAP_1AX = SETS_1AX;
	localparam logic [9:0] CAP_2AX = 10'(SETS_2AX * 2);
	localparam logic [9:0] CAP_3AX = 10'(SETS_3AX * 3);
	localparam logic [2:0] MARK_PAD = 3'h0;

	// ==========================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_STATUS_A = 8'h04;
	localparam logic [7:0] IDX_STATUS_B = 8'h05;
	localparam logic [7:0] IDX_DATA_HI = 8'h08;
	localparam logic [7:0] IDX_DATA_LO = 8'h09;
	localparam logic [7:0] IDX_WM_LOW = 8'h39;
	localparam logic [7:0] IDX_CTRL = 8'h3a;
	localparam logic [7:0] IDX_POP = 8'h3b;
	localparam logic [7:0] IDX_ROUTE_A = 8'h3c;
	localparam logic [7:0] IDX_ROUTE_B = 8'h3d;
	localparam logic [7:0] IDX_TIMING = 8'h3e;

	// ==========================================
	// Reset values and fields
	localparam logic [7:0] WM_LOW_RST = 8'h80;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] ROUTE_RST = 8'h00;
	localparam logic [1:0] TIMING_RST = 2'h0;
	localparam int CTRL_WM_MSB = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_FMT_LSB = 3;
	localparam int ROUTE_POL = 7;
	localparam int TIM_TRIG = 0;
	localparam int TIM_TIMEBASE = 1;

	// Event vector: status_a low nibble, status_b in the upper three bits
	localparam int EV_N = 7;
	localparam int EV_NEW = 0;
	localparam int EV_NEMPTY = 1;
	localparam int EV_WM = 2;
	localparam int EV_OVR = 3;
	localparam int EV_MOTION = 4;
	localparam int EV_STILL = 5;
	localparam int EV_WARN = 6;

	typedef enum logic [1:0] {
		SFR_OFF = 2'b00,
		SFR_STREAM = 2'b01,
		SFR_TRIG = 2'b10,
		SFR_OLDEST = 2'b11
	} sfr_mode_e;

	typedef enum logic [1:0] {
		FMT_1AX = 2'b00,
		FMT_2AX = 2'b01,
		FMT_3AX = 2'b10,
		FMT_PEAK = 2'b11
	} sfr_fmt_e;

	typedef enum logic [1:0] {
		PH_FILL = 2'b00,
		PH_POST = 2'b01,
		PH_HELD = 2'b10
	} sfr_phase_e;
endpackage : sfr_pkg

// ===== pkg/sfr_mem_if.sv
`timescale 1ns/1ns
interface sfr_mem_if;
	logic we;
	logic [sfr_pkg::AW-1:0] waddr;
	logic [15:0] wdata;
	logic [sfr_pkg::AW-1:0] raddr;
	logic [15:0] rdata;

	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sfr_mem_if

// ===== rtl/sfr_mem.sv
`timescale 1ns/1ns
module sfr_mem (
	input wire logic clk_i, // Sample clock
	sfr_mem_if.mem port_b // Write and read port
);
	// ==========================================
	// Storage array, one 16-bit item per entry
	logic [15:0] ram [0:(1 << sfr_pkg::AW)-1];

	always_ff @(posedge clk_i) begin
		if (port_b.we) begin
			ram[port_b.waddr] <= port_b.wdata;
		end
	end

	assign port_b.rdata = ram[port_b.raddr];
endmodule : sfr_mem

// ===== rtl/sfr_pin.sv
`timescale 1ns/1ns
module sfr_pin (
	input wire logic clk_i, // Sample clock
	input wire logic srst_i, // Synchronous reset
	input wire logic [sfr_pkg::EV_N-1:0] ev_i, // Event flags
	input wire logic [7:0] route_i, // Routing register
	input wire logic alt_i, // Pin used as input
	input wire logic pin_i, // Pin level in
	output logic pin_o, // Pin level out
	output logic pin_oe_n_o, // Output enable, low drives
	output logic alt_o // Input function level
);
	// ==========================================
	// Pin driver
	logic hit;
	logic none;

	assign hit = |(ev_i & route_i[sfr_pkg::EV_N-1:0]);
	assign none = ~|route_i[sfr_pkg::EV_N-1:0];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_o <= 1'h0;
			pin_oe_n_o <= 1'h1;
			alt_o <= 1'h0;
		end else begin
			pin_oe_n_o <= alt_i | none;
			pin_o <= hit ^ route_i[sfr_pkg::ROUTE_POL];
			alt_o <= alt_i & pin_i;
		end
	end
endmodule : sfr_pin

// ===== rtl/sfr_top.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
// Behaviour
// - 512-entry buffer filled from sample path
// - Capacity depends on axis format
// - Mode 00 stops and empties buffer
// - Mode 11 fills once then stops
// - Mode 01 drops oldest when full
// - Watermark flag at programmed count
// - Mode 10 stores count more, freezes
// - Pop port address fixed, pops bytes
// - Item upper byte first, data left-justified
// - Bit 0 marks series first item
// - Pins OR their routed sources
// - Unrouted or reset pin high impedance
// - Polarity bit makes pin active low
// - Status_b read clears motion, stillness while timer_zero_i low
// - Warning clears on standby then restart
// - Data register read clears new flag
// - Buffer flags clear on status_a read, overrun only when buffer empty
// - Alternate pin function disables signalling
// - Watermark level flag, count resets 0x80
// - Non-empty in mode 10 only after trigger capture
// - Overrun on replace or no room
module sfr_top (
	input wire logic clk_i, // Sample clock, 25 MHz
	input wire logic srst_i, // Synchronous reset
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [11:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic pready_o, // APB ready
	output logic [31:0] prdata_o, // APB read data
	output logic pslverr_o, // APB error
	input wire logic smp_valid_i, // New sample pulse
	input wire logic [11:0] smp_data_i, // Sample value
	input wire logic motion_i, // Motion detected pulse
	input wire logic stillness_i, // Stillness detected pulse
	input wire logic motion_warning_i, // Warning pulse
	input wire logic measure_on_i, // High in measurement
	input wire logic timer_zero_i, // Default linking, timer 0
	input wire logic irq_pin_a_i, // Pin a level in
	output logic irq_pin_a_o, // Pin a level out
	output logic irq_pin_a_oe_n_o, // Pin a enable, low drives
	input wire logic irq_pin_b_i, // Pin b level in
	output logic irq_pin_b_o, // Pin b level out
	output logic irq_pin_b_oe_n_o, // Pin b enable, low drives
	output logic ext_timebase_o, // Pin a as clock in
	output logic ext_trigger_o // Pin b as sync in
);
	// ==========================================
	// APB slave
	logic ack_q;
	logic [31:0] prdata_q;
	logic slverr_q;
	logic [7:0] idx;
	logic aligned;
	logic acc;
	logic wr_go;
	logic rd_go;
	logic hit;
	logic [7:0] rd_val;

	assign idx = paddr_i[9:2];
	assign aligned = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
	assign acc = psel_i & penable_i & ack_q;
	assign wr_go = acc & pwrite_i & hit;
	assign rd_go = acc & ~pwrite_i & hit;
	assign pready_o = ack_q;
	assign prdata_o = prdata_q;
	assign pslverr_o = slverr_q;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_q <= 1'h0;
		end else begin
			ack_q <= psel_i & penable_i & ~ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prdata_q <= 32'h0;
			slverr_q <= 1'h0;
		end else if (psel_i & penable_i & ~ack_q) begin
			prdata_q <= (pwrite_i || !hit) ? 32'h0 : {24'h0, rd_val};
			slverr_q <= ~hit;
		end
	end

	// ==========================================
	// Configuration registers
	logic [7:0] wm_low_q;
	logic [7:0] ctrl_q;
	logic [7:0] route_q [2];
	logic [1:0] timing_q;
	sfr_pkg::sfr_mode_e mode;
	sfr_pkg::sfr_fmt_e fmt;
	logic [8:0] wm;
	logic [9:0] cap;
	logic enabled;

	assign mode = sfr_pkg::sfr_mode_e'(ctrl_q[sfr_pkg::CTRL_MODE_LSB +: 2]);
	assign fmt = sfr_pkg::sfr_fmt_e'(ctrl_q[sfr_pkg::CTRL_FMT_LSB +: 2]);
	assign wm = {ctrl_q[sfr_pkg::CTRL_WM_MSB], wm_low_q};
	assign enabled = mode != sfr_pkg::SFR_OFF;

	always_comb begin
		unique case (fmt)
			sfr_pkg::FMT_1AX: cap = sfr_pkg::CAP_1AX;
			sfr_pkg::FMT_2AX: cap = sfr_pkg::CAP_2AX;
			sfr_pkg::FMT_3AX: cap = sfr_pkg::CAP_3AX;
			sfr_pkg::FMT_PEAK: cap = sfr_pkg::CAP_3AX;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wm_low_q <= sfr_pkg::WM_LOW_RST;
			ctrl_q <= sfr_pkg::CTRL_RST;
			route_q[0] <= sfr_pkg::ROUTE_RST;
			route_q[1] <= sfr_pkg::ROUTE_RST;
			timing_q <= sfr_pkg::TIMING_RST;
		end else if (wr_go) begin
			if (idx == sfr_pkg::IDX_WM_LOW) begin
				wm_low_q <= pwdata_i[7:0];
			end
			if (idx == sfr_pkg::IDX_CTRL) begin
				ctrl_q <= pwdata_i[7:0];
			end
			if (idx == sfr_pkg::IDX_ROUTE_A) begin
				route_q[0] <= pwdata_i[7:0];
			end
			if (idx == sfr_pkg::IDX_ROUTE_B) begin
				route_q[1] <= pwdata_i[7:0];
			end
			if (idx == sfr_pkg::IDX_TIMING) begin
				timing_q <= pwdata_i[1:0];
			end
		end
	end

	// ==========================================
	// Buffer pointers and capture sequence
	sfr_mem_if mif ();
	logic [9:0] count_q;
	logic [8:0] wptr_q;
	logic [8:0] rptr_q;
	logic [8:0] post_q;
	logic series_q;
	logic byte_q;
	logic [11:0] last_q;
	sfr_pkg::sfr_phase_e phase_q;
	logic [sfr_pkg::EV_N-1:0] ev_q;
	logic avail;
	logic pop_rd;
	logic pop;
	logic keep_full;
	logic store_ok;
	logic push;
	logic drop;
	logic ovr_ev;

	assign avail = (count_q != 10'h0) &&
		(mode != sfr_pkg::SFR_TRIG || phase_q == sfr_pkg::PH_HELD);
	assign pop_rd = rd_go && idx == sfr_pkg::IDX_POP && avail;
	assign pop = pop_rd & byte_q;
	assign keep_full = (count_q >= cap) && !pop;
	assign store_ok = smp_valid_i && enabled && phase_q != sfr_pkg::PH_HELD;
	assign drop = store_ok && keep_full && mode != sfr_pkg::SFR_OLDEST;
	assign push = store_ok && !(keep_full && mode == sfr_pkg::SFR_OLDEST);
	assign ovr_ev = smp_valid_i && enabled && keep_full &&
		(phase_q != sfr_pkg::PH_HELD || mode == sfr_pkg::SFR_OLDEST);

	assign mif.we = push;
	assign mif.waddr = wptr_q;
	assign mif.wdata = {smp_data_i, sfr_pkg::MARK_PAD, series_q};
	assign mif.raddr = rptr_q;

	sfr_mem u_mem (
		.clk_i(clk_i),
		.port_b(mif.mem)
	);

	always_ff @(posedge clk_i) begin
		if (srst_i || !enabled) begin
			count_q <= 10'h0;
			wptr_q <= 9'h0;
			rptr_q <= 9'h0;
		end else begin
			count_q <= count_q + 10'(push) - 10'(pop) - 10'(drop);
			if (push) begin
				wptr_q <= wptr_q + 9'h1;
			end
			if (pop || drop) begin
				rptr_q <= rptr_q + 9'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !enabled) begin
			series_q <= 1'h1;
			byte_q <= 1'h0;
		end else begin
			if (push) begin
				series_q <= 1'h0;
			end
			if (pop_rd) begin
				byte_q <= ~byte_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !enabled) begin
			phase_q <= sfr_pkg::PH_FILL;
			post_q <= 9'h0;
		end else begin
			unique case (phase_q)
				sfr_pkg::PH_FILL: begin
					post_q <= 9'h0;
					if (mode == sfr_pkg::SFR_OLDEST && push && count_q + 10'h1 >= cap) begin
						phase_q <= sfr_pkg::PH_HELD;
					end else if (mode == sfr_pkg::SFR_TRIG && motion_i) begin
						phase_q <= (wm == 9'h0) ? sfr_pkg::PH_HELD : sfr_pkg::PH_POST;
					end
				end
				sfr_pkg::PH_POST: begin
					if (push) begin
						post_q <= post_q + 9'h1;
						if (post_q + 9'h1 == wm) begin
							phase_q <= sfr_pkg::PH_HELD;
						end
					end
				end
				sfr_pkg::PH_HELD: begin
					if (mode == sfr_pkg::SFR_TRIG && count_q == 10'h0 && !ev_q[sfr_pkg::EV_MOTION]) begin
						phase_q <= sfr_pkg::PH_FILL;
					end
				end
				default: phase_q <= sfr_pkg::PH_FILL;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			last_q <= 12'h0;
		end else if (smp_valid_i) begin
			last_q <= smp_data_i;
		end
	end

	// ==========================================
	// Event flags
	logic meas_q;
	logic restart;
	logic sa_rd;
	logic sb_rd;
	logic data_rd;
	logic wm_cond;

	assign restart = measure_on_i & ~meas_q;
	assign sa_rd = rd_go && idx == sfr_pkg::IDX_STATUS_A;
	assign sb_rd = rd_go && idx == sfr_pkg::IDX_STATUS_B;
	assign data_rd = rd_go && (idx == sfr_pkg::IDX_DATA_HI || idx == sfr_pkg::IDX_DATA_LO);
	assign wm_cond = enabled && count_q >= {1'h0, wm};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meas_q <= 1'h0;
			ev_q <= '0;
		end else begin
			meas_q <= measure_on_i;
			ev_q[sfr_pkg::EV_NEW] <= smp_valid_i | (ev_q[sfr_pkg::EV_NEW] & ~data_rd);
			ev_q[sfr_pkg::EV_NEMPTY] <= avail | (ev_q[sfr_pkg::EV_NEMPTY] & ~sa_rd);
			ev_q[sfr_pkg::EV_WM] <= wm_cond | (ev_q[sfr_pkg::EV_WM] & ~sa_rd);
			ev_q[sfr_pkg::EV_OVR] <= ovr_ev | (ev_q[sfr_pkg::EV_OVR] & enabled &
				~(sa_rd & count_q == 10'h0));
			ev_q[sfr_pkg::EV_MOTION] <= motion_i | (ev_q[sfr_pkg::EV_MOTION] &
				~(sb_rd & ~timer_zero_i) & ~restart);
			ev_q[sfr_pkg::EV_STILL] <= stillness_i | (ev_q[sfr_pkg::EV_STILL] &
				~(sb_rd & ~timer_zero_i) & ~restart);
			ev_q[sfr_pkg::EV_WARN] <= motion_warning_i | (ev_q[sfr_pkg::EV_WARN] & ~restart);
		end
	end

	// ==========================================
	// Read decode
	always_comb begin
		hit = aligned;
		rd_val = 8'h0;
		unique case (idx)
			sfr_pkg::IDX_STATUS_A: rd_val = {4'h0, ev_q[sfr_pkg::EV_OVR:sfr_pkg::EV_NEW]};
			sfr_pkg::IDX_STATUS_B: rd_val = {5'h0, ev_q[sfr_pkg::EV_WARN:sfr_pkg::EV_MOTION]};
			sfr_pkg::IDX_DATA_HI: rd_val = last_q[11:4];
			sfr_pkg::IDX_DATA_LO: rd_val = {last_q[3:0], 4'h0};
			sfr_pkg::IDX_WM_LOW: rd_val = wm_low_q;
			sfr_pkg::IDX_CTRL: rd_val = ctrl_q;
			sfr_pkg::IDX_POP: rd_val = !avail ? 8'h0 :
				(byte_q ? mif.rdata[7:0] : mif.rdata[15:8]);
			sfr_pkg::IDX_ROUTE_A: rd_val = route_q[0];
			sfr_pkg::IDX_ROUTE_B: rd_val = route_q[1];
			sfr_pkg::IDX_TIMING: rd_val = {6'h0, timing_q};
			default: hit = 1'h0;
		endcase
	end

	// ==========================================
	// Interrupt pins
	logic [1:0] alt_sel;
	logic [1:0] pin_in;
	logic [1:0] pin_out;
	logic [1:0] pin_oe_n;
	logic [1:0] alt_lvl;

	assign alt_sel = {timing_q[sfr_pkg::TIM_TRIG], timing_q[sfr_pkg::TIM_TIMEBASE]};
	assign pin_in = {irq_pin_b_i, irq_pin_a_i};

	for (genvar g = 0; g < 2; g++) begin : g_pin
		sfr_pin u_pin (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.ev_i(ev_q),
			.route_i(route_q[g]),
			.alt_i(alt_sel[g]),
			.pin_i(pin_in[g]),
			.pin_o(pin_out[g]),
			.pin_oe_n_o(pin_oe_n[g]),
			.alt_o(alt_lvl[g])
		);
	end

	assign irq_pin_a_o = pin_out[0];
	assign irq_pin_a_oe_n_o = pin_oe_n[0];
	assign irq_pin_b_o = pin_out[1];
	assign irq_pin_b_oe_n_o = pin_oe_n[1];
	assign ext_timebase_o = alt_lvl[0];
	assign ext_trigger_o = alt_lvl[1];
endmodule : sfr_top

// ===== tb/sfr_monitor.sv
`timescale 1ns/1ns
module sfr_monitor (
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic psel_i, // Select
	input wire logic penable_i, // Enable
	input wire logic pwrite_i, // Direction
	input wire logic [11:0] paddr_i, // Address
	input wire logic pready_o, // Ready
	input wire logic [31:0] prdata_o, // Read data
	input wire logic pslverr_o, // Error
	input wire logic irq_pin_a_i, // Pin a in
	input wire logic irq_pin_a_oe_n_o, // Pin a enable
	input wire logic irq_pin_b_i, // Pin b in
	input wire logic irq_pin_b_oe_n_o, // Pin b enable
	input wire logic ext_timebase_o, // Pin a function
	input wire logic ext_trigger_o // Pin b function
);
	// ==========================================
	// Bus and pin relations
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	ack_one_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("ready late");
	ack_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
	ack_in_access_a: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	misalign_err_a: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
		else $error("misaligned not refused");
	err_read_zero_a: assert property (pready_o && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read not zero");
	upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper bits");
	reset_hiz_a: assert property ($fell(srst_i) |-> irq_pin_a_oe_n_o && irq_pin_b_oe_n_o)
		else $error("pins driven after reset");
	timebase_copy_a: assert property (ext_timebase_o |-> $past(irq_pin_a_i))
		else $error("timebase not pin a");
	trigger_copy_a: assert property (ext_trigger_o |-> $past(irq_pin_b_i))
		else $error("trigger not pin b");
	alt_a_quiet_a: assert property (ext_timebase_o |-> irq_pin_a_oe_n_o)
		else $error("pin a driven in input use");
	alt_b_quiet_a: assert property (ext_trigger_o |-> irq_pin_b_oe_n_o)
		else $error("pin b driven in input use");
	cover property (pready_o && pslverr_o);
	cover property (!irq_pin_a_oe_n_o && !irq_pin_b_oe_n_o);
	cover property (ext_timebase_o ##1 !ext_timebase_o);
endmodule : sfr_monitor

bind sfr_top sfr_monitor i_sfr_monitor (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pready_o, .prdata_o, .pslverr_o, .irq_pin_a_i, .irq_pin_a_oe_n_o,
	.irq_pin_b_i, .irq_pin_b_oe_n_o, .ext_timebase_o, .ext_trigger_o);

// ===== tb/sfr_host.sv
`timescale 1ns/1ns
module sfr_host (
	input wire logic clk_i, // Clock
	input wire logic drv_i, // Host drives pins as inputs
	input wire logic [1:0] lvl_i, // Device pin levels
	input wire logic [1:0] oe_n_i, // Device enables, low drives
	output logic [1:0] pin_o // Resolved pin levels
);
	logic [1:0] keep_q = 2'h0;
	logic tgl_q = 1'b0;
	always_ff @(posedge clk_i) begin
		tgl_q <= ~tgl_q;
		keep_q <= pin_o;
	end
	// Keepers hold a released pin; in input use the host clocks it
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			pin_o[k] = !oe_n_i[k] ? lvl_i[k] : (drv_i ? tgl_q : keep_q[k]);
		end
	end
endmodule : sfr_host

// ===== tb/sfr_bench.sv
`timescale 1ns/1ns
module sfr_bench;
	logic clk_i = 1'b0, srst_i = 1'b1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 12'h0, smp_data_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic pready_o, pslverr_o, smp_valid_i = 0, motion_i = 0, still_i = 0, warn_i = 0;
	logic meas_i = 0, tz_i = 0, drv = 0, fst = 0, pa_o, pa_oe, pb_o, pb_oe, ext_a, ext_b;
	logic [1:0] lo = 2'h0;
	int cap = 512;
	logic [1:0] pins;
	logic [7:0] rd;
	logic [12:0] q[$];
	int n_fail = 0, checks_done = 0, seed = 32'h76a56519;
	always #20 clk_i = ~clk_i;
	sfr_top i_sfr_top (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i), .motion_i(motion_i),
		.stillness_i(still_i), .motion_warning_i(warn_i), .measure_on_i(meas_i),
		.timer_zero_i(tz_i), .irq_pin_a_i(pins[0]), .irq_pin_a_o(pa_o),
		.irq_pin_a_oe_n_o(pa_oe), .irq_pin_b_i(pins[1]), .irq_pin_b_o(pb_o),
		.irq_pin_b_oe_n_o(pb_oe), .ext_timebase_o(ext_a), .ext_trigger_o(ext_b));
	sfr_host i_sfr_host (.clk_i(clk_i), .drv_i(drv), .lvl_i({pb_o, pa_o}),
		.oe_n_i({pb_oe, pa_oe}), .pin_o(pins));
	// ==========================================
	// Tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int w;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {2'h0, idx, lo};
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		w = 0;
		do begin
			@(posedge clk_i);
			w++;
		end while (pready_o !== 1'b1 && w < 20);
		rd = prdata_o[7:0];
		if (w >= 20) begin
			n_fail++;
			complete_run();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h0);
		chk(rd, exp);
	endtask : rdc
	task automatic push(input int n, input bit old);
		logic [11:0] v;
		repeat (n) begin
			v = 12'($random(seed));
			smp_valid_i <= 1'b1;
			smp_data_i <= v;
			if (q.size() == cap && !old) void'(q.pop_front());
			if (q.size() < cap) q.push_back({v, fst});
			fst = 1'b0;
			@(posedge clk_i);
		end
		smp_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask : push
	task automatic popchk(input int n);
		logic [12:0] e;
		repeat (n) begin
			e = q.pop_front();
			rdc(sfr_pkg::IDX_POP, e[12:5]);
			rdc(sfr_pkg::IDX_POP, {e[4:1], 3'h0, e[0]});
		end
	endtask : popchk
	task automatic pinchk(input int k, input logic [1:0] e);
		repeat (2) @(posedge clk_i);
		chk({6'h0, pins[k], k ? pb_oe : pa_oe}, {6'h0, e});
	endtask : pinchk
	task automatic setup(input logic [7:0] ctl);
		meas_i <= 1'b0;
		apb(1'b1, sfr_pkg::IDX_CTRL, 8'h00);
		apb(1'b1, sfr_pkg::IDX_CTRL, ctl);
		q.delete();
		fst = 1'b1;
		meas_i <= 1'b1;
	endtask : setup
	// ==========================================
	// Scenarios
	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rdc(sfr_pkg::IDX_WM_LOW, 8'h80);
		rdc(sfr_pkg::IDX_CTRL, 8'h00);
		rdc(8'h3f, 8'h00);
		lo = 2'h1;
		rdc(sfr_pkg::IDX_WM_LOW, 8'h00);
		lo = 2'h0;
		chk({7'h0, pslverr_o}, 8'h01);
		apb(1'b1, sfr_pkg::IDX_WM_LOW, 8'h03);
		apb(1'b1, sfr_pkg::IDX_ROUTE_A, 8'h02);
		setup(8'h02);
		push(514, 0);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h0f);
		pinchk(0, 2'b10);
		apb(1'b1, sfr_pkg::IDX_ROUTE_A, 8'h82);
		pinchk(0, 2'b00);
		apb(1'b1, sfr_pkg::IDX_ROUTE_A, 8'h00);
		pinchk(0, 2'b01);
		apb(1'b0, sfr_pkg::IDX_DATA_HI, 8'h0);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h0e);
		popchk(512);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h0e);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h00);
		push(3, 0);
		meas_i <= 1'b0;
		apb(1'b1, sfr_pkg::IDX_CTRL, 8'h00);
		apb(1'b0, sfr_pkg::IDX_STATUS_A, 8'h0);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h01);
		rdc(sfr_pkg::IDX_POP, 8'h00);
		setup(8'h07);
		push(258, 1);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h03);
		push(256, 1);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h0f);
		popchk(2);
		cap = 510;
		setup(8'h16);
		push(510, 1);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h07);
		push(1, 1);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h0f);
		popchk(3);
		cap = 512;
		apb(1'b1, sfr_pkg::IDX_WM_LOW, 8'h02);
		apb(1'b1, sfr_pkg::IDX_ROUTE_B, 8'h10);
		setup(8'h04);
		apb(1'b0, sfr_pkg::IDX_STATUS_A, 8'h0);
		push(4, 0);
		rdc(sfr_pkg::IDX_STATUS_A, 8'h05);
		motion_i <= 1'b1;
		@(posedge clk_i);
		motion_i <= 1'b0;
		pinchk(1, 2'b10);
		push(5, 0);
		repeat (3) void'(q.pop_back());
		rdc(sfr_pkg::IDX_STATUS_A, 8'h07);
		popchk(6);
		rdc(sfr_pkg::IDX_STATUS_B, 8'h01);
		rdc(sfr_pkg::IDX_STATUS_B, 8'h00);
		repeat (1012) rdc(sfr_pkg::IDX_POP, 8'h00);
		tz_i <= 1'b1;
		still_i <= 1'b1;
		warn_i <= 1'b1;
		@(posedge clk_i);
		still_i <= 1'b0;
		warn_i <= 1'b0;
		rdc(sfr_pkg::IDX_STATUS_B, 8'h06);
		rdc(sfr_pkg::IDX_STATUS_B, 8'h06);
		setup(8'h00);
		rdc(sfr_pkg::IDX_STATUS_B, 8'h00);
		apb(1'b1, sfr_pkg::IDX_TIMING, 8'h03);
		drv <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk({6'h0, pa_oe, pb_oe}, 8'h03);
		chk({6'h0, ext_a, ext_b}, {6'h0, ~pins[0], ~pins[1]});
		complete_run();
	end
endmodule : sfr_bench
